/* File: src/iin_limit_defs.svh */
// Offsets, field positions, reset values and weights of the input current limit registers
`ifndef IIN_LIMIT_DEFS_SVH
`define IIN_LIMIT_DEFS_SVH
`define HOST_LIMIT_LO_ADDR   8'h0E
`define HOST_LIMIT_HI_ADDR   8'h0F
`define EFF_LIMIT_LO_ADDR    8'h24
`define EFF_LIMIT_HI_ADDR    8'h25
`define LIMIT_RESET          16'h4100
`define LIMIT_HI_RESET       8'h41
`define LIMIT_RSVD_BIT       7
`define LIMIT_CODE_W         7
`define LIMIT_STEP_MA        16'h0032
`define LIMIT_MIN_MA         16'h0032
`endif

/* File: src/iin_limit_pkg.sv */
// Types shared by the input current limit register pair
package iin_limit_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       adapter_q;
    logic [7:0] host_hi;
    logic [7:0] eff_hi;
    logic [7:0] rdata;
    logic       rvalid;
  } limit_state_t;
endpackage : iin_limit_pkg

/* File: src/input_current_limit_regs.sv */
// Input current limit register pair: host setting and limit in force
//
// Contract
// - Bit 7 of the host limit high byte is reserved and a write with it set is refused.
// - Host high byte bits 6..0 weigh 3200 mA down to 50 mA and are summed into the limit.
// - The host limit register resets to 4100h.
// - The host limit low byte is reserved, reads as zero, and ignores writes.
// - The effective register reports the limit in force, from the host or the optimizer.
// - After an optimizer run the effective register holds the optimizer result.
// - Effective code zero means a 50 mA limit, not zero current.
// - The effective limit register resets to 4100h.
// - Adapter removal restores the host limit register to its 3.25 A default.
// - A host code of zero applies a 50 mA limit.
`timescale 1ns/10ps
`include "iin_limit_defs.svh"

module input_current_limit_regs
(
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rst_b_in,
  // Register port, same clock as the serial front end
  input  wire iin_limit_pkg::reg_req_t req_in,
  output logic [7:0]                  rdata_out,
  output logic                        rvalid_out,
  // Optimizer and adapter status
  input  wire logic                   adapter_present_in,
  input  wire logic                   optimizer_done_in,
  input  wire logic [6:0]             optimizer_code_in,
  // Limit applied by regulation
  output logic [6:0]                  limit_code_out,
  output logic [15:0]                 limit_ma_out
);

  iin_limit_pkg::limit_state_t state_reg;
  iin_limit_pkg::limit_state_t state_next;
  logic                        rst_s1_b_reg;
  logic                        rst_b_reg;
  logic                        adapter_lost;
  logic                        host_wr_ok;
  logic                        opt_load;
  logic [7:0]                  read_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Sum of the binary weights of the set code bits
  function automatic logic [15:0] code_weight_sum(input logic [6:0] code);
    logic [15:0] ma;
    ma = 16'h0000;
    for (int i = 0; i < `LIMIT_CODE_W; i++)
    begin
      if (code[i])
      begin
        ma = ma + (`LIMIT_STEP_MA << i);
      end
    end
    return ma;
  endfunction : code_weight_sum

  ////////////////////////////////////////////////////////////////////////////
  // Code to milliamps; zero still means one step, never zero current
  function automatic logic [15:0] code_to_ma(input logic [6:0] code);
    logic [15:0] ma;
    ma = code_weight_sum(code);
    if (code == 7'h00)
    begin
      ma = `LIMIT_MIN_MA;
    end
    return ma;
  endfunction : code_to_ma

  ////////////////////////////////////////////////////////////////////////////
  // A host write lands only on the high byte with the reserved bit clear
  function automatic logic host_write_valid(input iin_limit_pkg::reg_req_t req);
    logic ok;
    ok = 1'b0;
    if (req.wr && (req.addr == `HOST_LIMIT_HI_ADDR))
    begin
      ok = !req.wdata[`LIMIT_RSVD_BIT];
    end
    return ok;
  endfunction : host_write_valid

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer; low bytes and unmapped offsets read as zero
  function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                          input logic [7:0] host_hi,
                                          input logic [7:0] eff_hi);
    logic [7:0] data;
    data = 8'h00;
    case (addr)
      `HOST_LIMIT_HI_ADDR: data = host_hi;
      `EFF_LIMIT_HI_ADDR:  data = eff_hi;
      `HOST_LIMIT_LO_ADDR: data = 8'h00;
      `EFF_LIMIT_LO_ADDR:  data = 8'h00;
      default:             data = 8'h00;
    endcase
    return data;
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_s1_b_reg <= 1'b0;
      rst_b_reg    <= 1'b0;
    end
    else
    begin
      rst_s1_b_reg <= 1'b1;
      rst_b_reg    <= rst_s1_b_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event decode
  // Falling edge of the synchronised pin; the flop after the pair holds the old level
  assign adapter_lost = state_reg.adapter_q & ~state_reg.sync2;
  assign host_wr_ok   = host_write_valid(req_in);
  assign opt_load     = optimizer_done_in;
  assign read_byte    = read_mux(req_in.addr, state_reg.host_hi, state_reg.eff_hi);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    state_next           = state_reg;

    // Adapter pin is asynchronous, so two flops before use
    state_next.sync1     = adapter_present_in;
    state_next.sync2     = state_reg.sync1;
    state_next.adapter_q = state_reg.sync2;

    // Host setting; it becomes the limit in force until the next optimizer run
    if (host_wr_ok)
    begin
      state_next.host_hi = req_in.wdata;
      state_next.eff_hi  = req_in.wdata;
    end
    // Low byte and effective writes fall through untouched

    // Optimizer result overrides a same-cycle host write
    if (opt_load)
    begin
      state_next.eff_hi = {1'b0, optimizer_code_in};
    end

    // Removal wins over a same-cycle write: the default must hold
    if (adapter_lost)
    begin
      state_next.host_hi = `LIMIT_HI_RESET;
      state_next.eff_hi  = `LIMIT_HI_RESET;
    end

    // Read answer stands one cycle, zero otherwise
    state_next.rvalid    = req_in.rd;
    state_next.rdata     = 8'h00;
    if (req_in.rd)
    begin
      state_next.rdata = read_byte;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_reg)
  begin
    if (!rst_b_reg)
    begin
      state_reg           <= '0;
      state_reg.host_hi   <= `LIMIT_HI_RESET;
      state_reg.eff_hi    <= `LIMIT_HI_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rdata_out      = state_reg.rdata;
  assign rvalid_out     = state_reg.rvalid;
  assign limit_code_out = state_reg.eff_hi[6:0];
  assign limit_ma_out   = code_to_ma(state_reg.eff_hi[6:0]);

endmodule : input_current_limit_regs

/* File: testbench/iin_limit_checker.sv */
// Port checker for the input current limit registers
`timescale 1ns/10ps
module iin_limit_checker (
  input wire logic mclk_in, rst_b_in, rvalid_out, adapter_present_in, optimizer_done_in,
  input wire iin_limit_pkg::reg_req_t req_in,
  input wire logic [7:0] rdata_out,
  input wire logic [6:0] optimizer_code_in, limit_code_out,
  input wire logic [15:0] limit_ma_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  a_read_pulse: assert property (rvalid_out == $past(req_in.rd)) else $error("rvalid");
  a_idle_zero: assert property (!rvalid_out |-> rdata_out == 8'h00) else $error("rdata");
  a_top_clear: assert property (rvalid_out |-> !rdata_out[7]) else $error("bit7");
  a_ma_value: assert property (limit_ma_out == (limit_code_out == 7'h00 ? 16'h0032 :
    {9'h000, limit_code_out} * 16'h0032)) else $error("mA");
  a_host_load: assert property (adapter_present_in[*4] ##0 (req_in.wr && req_in.addr == 8'h0F
    && !req_in.wdata[7] && !optimizer_done_in) |=> limit_code_out == $past(req_in.wdata[6:0]))
    else $error("host write");
  a_bad_write: assert property (adapter_present_in[*4] ##0 (req_in.wr && !optimizer_done_in
    && (req_in.addr != 8'h0F || req_in.wdata[7])) |=> $stable(limit_code_out)) else $error("wr");
  a_opt_load: assert property (adapter_present_in[*4] ##0 optimizer_done_in |=>
    limit_code_out == $past(optimizer_code_in)) else $error("optimizer");
  a_unplug: assert property ($fell(adapter_present_in) |-> ##[2:4] limit_code_out == 7'h41)
    else $error("unplug");
endmodule : iin_limit_checker
bind input_current_limit_regs iin_limit_checker chk (.*);

/* File: testbench/host_model.sv */
// Host controller model on the byte register port
`timescale 1ns/10ps
module host_model (
  input  wire logic               mclk_in,
  input  wire logic [7:0]         rdata_in,
  output iin_limit_pkg::reg_req_t req_out
);
  initial req_out = '0;
  // Request held one full cycle so the taking edge always sees it
  task automatic put(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge mclk_in) req_out <= {w, !w, a, d};
    @(posedge mclk_in) req_out <= '0;
    #1 q = rdata_in;
  endtask : put
endmodule : host_model

/* File: testbench/input_current_limit_regs_tb.sv */
// Self-checking bench for the input current limit registers
`timescale 1ns/10ps
module input_current_limit_regs_tb;
  logic mclk_in = 0, rst_b_in = 0, adapter = 1, done = 0, rv;
  logic [6:0] ocode = 7'h00, code, e_host = 7'h41, e_eff = 7'h41;
  logic [7:0] rdata, q, d, a;
  logic [15:0] ma;
  iin_limit_pkg::reg_req_t req;
  int seed = 97726, bad_count = 0, compares = 0, cyc = 0;
  always #5 mclk_in = ~mclk_in;
  host_model host (.mclk_in(mclk_in), .rdata_in(rdata), .req_out(req));
  input_current_limit_regs dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .req_in(req),
    .rdata_out(rdata), .rvalid_out(rv), .adapter_present_in(adapter), .optimizer_done_in(done),
    .optimizer_code_in(ocode), .limit_code_out(code), .limit_ma_out(ma));
  task automatic chk(input logic [15:0] got, want);
    compares++;
    if (got !== want)
    begin
      bad_count++;
      $display("unexpected %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic rd(input logic [7:0] ad, input logic [6:0] w);
    host.put(1'b0, ad, 8'h00, q);
    chk({8'h00, q}, {9'h000, w});
    chk({15'h0000, rv}, 16'h0001);
    chk({9'h000, code}, {9'h000, e_eff});
    chk(ma, e_eff == 7'h00 ? 16'h0032 : 16'(e_eff * 50));
  endtask : rd
  task automatic report_and_stop;
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rd(8'h0F, 7'h41);
    rd(8'h25, 7'h41);
    rd(8'h0E, 7'h00);
    rd(8'h24, 7'h00);
    for (int i = 0; i < 12; i++)
    begin
      d = (i == 0) ? 8'h00 : 8'($random(seed));
      a = (i % 3 == 2) ? 8'h25 : (i % 4 == 3) ? 8'h0E : 8'h0F;
      host.put(1'b1, a, d, q);
      chk({7'h00, rv, q}, 16'h0000);
      if (a == 8'h0F && !d[7])
      begin
        e_host = d[6:0];
        e_eff = d[6:0];
      end
      rd(8'h0F, e_host);
      rd(8'h25, e_eff);
    end
    for (int j = 0; j < 2; j++)
    begin
      @(posedge mclk_in);
      ocode <= (j == 0) ? 7'h00 : 7'($random(seed));
      done <= 1'b1;
      @(posedge mclk_in);
      done <= 1'b0;
      e_eff = ocode;
      rd(8'h25, e_eff);
      rd(8'h0F, e_host);
    end
    @(posedge mclk_in);
    adapter <= 1'b0;
    repeat (6) @(posedge mclk_in);
    e_eff = 7'h41;
    e_host = 7'h41;
    adapter <= 1'b1;
    rd(8'h0F, e_host);
    rd(8'h10, 7'h00);
    report_and_stop();
  end
endmodule : input_current_limit_regs_tb
